// >>> core/pll_pkg.sv
// Package of constants for the clock synthesis loop
// What this block does
// - At most eight loops, one copy each
// - Reference from own pin, primary on own net
// - Divided secondary drives the neighbouring net
// - Loop reset from fabric or dedicated pin
// - Feedback from pin or internal net tap
// - Lock indication driven straight into fabric
// - Input divider divides the reference
// - Feedback divider multiplies synthesized frequency
// - Post divider lets oscillator run faster
// - Secondary divider used only when enabled
// - Delay on reference or feedback path
package pll_pkg;
    localparam int MAX_LOOPS = 8;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV_IN = 8'h04;
    localparam logic [7:0] ADDR_DIV_FB = 8'h08;
    localparam logic [7:0] ADDR_DIV_POST = 8'h0C;
    localparam logic [7:0] ADDR_DIV_SEC = 8'h10;
    localparam logic [7:0] ADDR_DELAY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // ----------------------------------------
    // Control and status fields
    // ----------------------------------------
    localparam int CTRL_W = 5;
    localparam int CTRL_RST_PIN = 0;
    localparam int CTRL_FB_PIN = 1;
    localparam int CTRL_SEC_EN = 2;
    localparam int CTRL_DLY_FB = 3;
    localparam int CTRL_SOFT_RST = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam int DIV_RESET = 1;
    localparam int DELAY_RESET = 0;
    localparam int STAT_LOCK = 0;
    localparam int STAT_IN_RST = 1;
    // ----------------------------------------
    // Oscillator and lock detector
    // ----------------------------------------
    localparam int NCO_W = 16;
    localparam logic [NCO_W-1:0] STEP_RESET = 16'h0400;
    localparam logic [NCO_W-1:0] STEP_GAIN = 16'h0100;
    localparam logic [NCO_W-1:0] STEP_MAX = 16'h7FFF;
    localparam int LOCK_CNT_W = 4;
    localparam logic [LOCK_CNT_W-1:0] LOCK_COUNT = 4'h8;
endpackage : pll_pkg

// >>> core/pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [WIDTH-1:0] d_in, // Asynchronous inputs
    output logic [WIDTH-1:0] d_out // Synchronised outputs
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_out = sync_q;
endmodule : pin_sync

// >>> core/edge_divider.sv
// Divider counting rising edges of a level
`timescale 1ns/1ns
module edge_divider #(
    parameter int W = 8
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic clr, // Holds the divider cleared
    input wire logic [W-1:0] div, // Division ratio, zero acts as one
    input wire logic in_level, // Level to divide
    output logic tick, // Pulse once per div rising edges
    output logic level // Divided level
);
    logic prev_q;
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] d_eff;
    logic rise;
    logic last;

    assign d_eff = (div == '0) ? W'(1) : div;
    assign rise = in_level & ~prev_q;
    // Compare with >= so a shrinking ratio cannot strand the count
    assign last = (cnt_q >= d_eff - W'(1));
    assign cnt_d = rise ? (last ? '0 : cnt_q + W'(1)) : cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_b || clr) begin
            prev_q <= 1'b0;
            cnt_q <= '0;
            tick <= 1'b0;
            level <= 1'b0;
        end else begin
            prev_q <= in_level;
            cnt_q <= cnt_d;
            tick <= rise & last;
            level <= (d_eff == W'(1)) ? in_level : (cnt_d < (d_eff >> 1));
        end
    end
endmodule : edge_divider

// >>> core/pll_clock_synthesis.sv
// Digital model of one clock synthesis loop with register port
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module pll_clock_synthesis #(
    parameter int LOOP_INDEX = 0,
    parameter int DIV_W = 8,
    parameter int DLY_TAPS = 16
) (
    input wire logic clk, // System clock, 25 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic global_clock_pin_zero, // Reference clock pin
    input wire logic loop_feedback_in, // Feedback pin
    input wire logic loop_reset_pin, // Loop reset pin, active high
    input wire logic loop_reset_fabric, // Loop reset from routing, active high
    input wire logic [7:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd
    output logic global_clock_net_zero, // Primary clock net
    output logic global_clock_net_one, // Secondary clock net
    output logic loop_lock // Lock indication to fabric
);
    localparam int DLY_SEL_W = $clog2(DLY_TAPS);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_s;
    logic ref_s;
    logic fb_pin_s;
    logic rst_pin_s;
    logic rst_fab_s;

    pin_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d_in({loop_reset_fabric, loop_reset_pin, loop_feedback_in, global_clock_pin_zero}),
        .d_out(pins_s)
    );

    assign ref_s = pins_s[0];
    assign fb_pin_s = pins_s[1];
    assign rst_pin_s = pins_s[2];
    assign rst_fab_s = pins_s[3];

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [pll_pkg::CTRL_W-1:0] ctrl_q;
    logic [DIV_W-1:0] div_in_q;
    logic [DIV_W-1:0] div_fb_q;
    logic [DIV_W-1:0] div_post_q;
    logic [DIV_W-1:0] div_sec_q;
    logic [DLY_SEL_W-1:0] dly_q;
    logic [31:0] rdata_q;
    logic loop_rst_q;
    logic lock_q;
    logic net_zero_q;
    logic net_one_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= pll_pkg::CTRL_RESET;
            div_in_q <= DIV_W'(pll_pkg::DIV_RESET);
            div_fb_q <= DIV_W'(pll_pkg::DIV_RESET);
            div_post_q <= DIV_W'(pll_pkg::DIV_RESET);
            div_sec_q <= DIV_W'(pll_pkg::DIV_RESET);
            dly_q <= DLY_SEL_W'(pll_pkg::DELAY_RESET);
        end else if (wr) begin
            case (addr)
                pll_pkg::ADDR_CTRL: ctrl_q <= wdata[pll_pkg::CTRL_W-1:0];
                pll_pkg::ADDR_DIV_IN: div_in_q <= wdata[DIV_W-1:0];
                pll_pkg::ADDR_DIV_FB: div_fb_q <= wdata[DIV_W-1:0];
                pll_pkg::ADDR_DIV_POST: div_post_q <= wdata[DIV_W-1:0];
                pll_pkg::ADDR_DIV_SEC: div_sec_q <= wdata[DIV_W-1:0];
                pll_pkg::ADDR_DELAY: dly_q <= wdata[DLY_SEL_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data stands for one cycle only, unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_b || !rd) begin
            rdata_q <= '0;
        end else begin
            case (addr)
                pll_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
                pll_pkg::ADDR_DIV_IN: rdata_q <= 32'(div_in_q);
                pll_pkg::ADDR_DIV_FB: rdata_q <= 32'(div_fb_q);
                pll_pkg::ADDR_DIV_POST: rdata_q <= 32'(div_post_q);
                pll_pkg::ADDR_DIV_SEC: rdata_q <= 32'(div_sec_q);
                pll_pkg::ADDR_DELAY: rdata_q <= 32'(dly_q);
                pll_pkg::ADDR_STATUS: rdata_q <= 32'({loop_rst_q, lock_q});
                default: rdata_q <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // Loop reset and path selection
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loop_rst_q <= 1'b1;
        end else begin
            loop_rst_q <= ctrl_q[pll_pkg::CTRL_SOFT_RST] |
                (ctrl_q[pll_pkg::CTRL_RST_PIN] ? rst_pin_s : rst_fab_s);
        end
    end

    logic fb_raw;
    logic dly_in;
    logic dly_out;
    logic ref_level;
    logic fb_level;
    logic [DLY_TAPS-1:0] dly_line_q;

    assign fb_raw = ctrl_q[pll_pkg::CTRL_FB_PIN] ? fb_pin_s : net_zero_q;
    assign dly_in = ctrl_q[pll_pkg::CTRL_DLY_FB] ? fb_raw : ref_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dly_line_q <= '0;
        end else begin
            dly_line_q <= {dly_line_q[DLY_TAPS-2:0], dly_in};
        end
    end

    // Delay on feedback advances the output, on reference retards it
    assign dly_out = dly_line_q[dly_q];
    assign ref_level = ctrl_q[pll_pkg::CTRL_DLY_FB] ? ref_s : dly_out;
    assign fb_level = ctrl_q[pll_pkg::CTRL_DLY_FB] ? dly_out : fb_raw;

    // ----------------------------------------
    // Oscillator and dividers
    // ----------------------------------------
    logic [pll_pkg::NCO_W-1:0] acc_q;
    logic [pll_pkg::NCO_W-1:0] step_q;
    logic [2*DIV_W-1:0] ref_ratio;
    logic vco_level;
    logic ref_tick;
    logic fb_tick;
    logic prim_level;
    logic sec_level;

    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + step_q;
        end
    end
    assign vco_level = acc_q[pll_pkg::NCO_W-1];
    assign ref_ratio = (2*DIV_W)'(div_in_q | DIV_W'(div_in_q == '0)) *
        (2*DIV_W)'(div_post_q | DIV_W'(div_post_q == '0));
    edge_divider #(.W(2*DIV_W)) u_div_in (
        .clk(clk),
        .rst_b(rst_b),
        .clr(loop_rst_q),
        .div(ref_ratio),
        .in_level(ref_level),
        .tick(ref_tick),
        .level()
    );

    edge_divider #(.W(DIV_W)) u_div_post (
        .clk(clk),
        .rst_b(rst_b),
        .clr(loop_rst_q),
        .div(div_post_q),
        .in_level(vco_level),
        .tick(),
        .level(prim_level)
    );

    edge_divider #(.W(DIV_W)) u_div_fb (
        .clk(clk),
        .rst_b(rst_b),
        .clr(loop_rst_q),
        .div(div_fb_q),
        .in_level(fb_level),
        .tick(fb_tick),
        .level()
    );

    edge_divider #(.W(DIV_W)) u_div_sec (
        .clk(clk),
        .rst_b(rst_b),
        .clr(loop_rst_q | ~ctrl_q[pll_pkg::CTRL_SEC_EN]),
        .div(div_sec_q),
        .in_level(net_zero_q),
        .tick(),
        .level(sec_level)
    );

    // ----------------------------------------
    // Frequency detector and lock
    // ----------------------------------------
    logic [1:0] fb_cnt_q;
    logic [pll_pkg::LOCK_CNT_W-1:0] lock_cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            fb_cnt_q <= 2'h0;
        end else if (ref_tick) begin
            fb_cnt_q <= {1'b0, fb_tick};
        end else if (fb_tick && fb_cnt_q != 2'h3) begin
            fb_cnt_q <= fb_cnt_q + 2'h1;
        end
    end

    // One feedback tick per divided reference tick is the target
    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            step_q <= pll_pkg::STEP_RESET;
        end else if (ref_tick) begin
            if (fb_cnt_q == 2'h0 && step_q <= pll_pkg::STEP_MAX - pll_pkg::STEP_GAIN) begin
                step_q <= step_q + pll_pkg::STEP_GAIN;
            end else if (fb_cnt_q > 2'h1 && step_q > pll_pkg::STEP_GAIN) begin
                step_q <= step_q - pll_pkg::STEP_GAIN;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            lock_cnt_q <= '0;
        end else if (ref_tick) begin
            if (fb_cnt_q != 2'h1) begin
                lock_cnt_q <= '0;
            end else if (lock_cnt_q != pll_pkg::LOCK_COUNT) begin
                lock_cnt_q <= lock_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= (lock_cnt_q == pll_pkg::LOCK_COUNT);
        end
    end

    // ----------------------------------------
    // Output nets
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b || loop_rst_q) begin
            net_zero_q <= 1'b0;
            net_one_q <= 1'b0;
        end else begin
            net_zero_q <= prim_level;
            net_one_q <= ctrl_q[pll_pkg::CTRL_SEC_EN] & sec_level;
        end
    end

    assign rdata = rdata_q;
    assign global_clock_net_zero = net_zero_q;
    assign global_clock_net_one = net_one_q;
    assign loop_lock = lock_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_loop_index;
        LOOP_INDEX < pll_pkg::MAX_LOOPS;
    endproperty
    a_loop_index: assert property (p_loop_index) else $error("loop index too large");

    property p_lock_low_in_reset;
        loop_rst_q |=> !loop_lock;
    endproperty
    a_lock_low_in_reset: assert property (p_lock_low_in_reset)
        else $error("lock high during loop reset");

    property p_lock_after_count;
        $rose(loop_lock) |-> $past(lock_cnt_q) == pll_pkg::LOCK_COUNT && !$past(loop_rst_q);
    endproperty
    a_lock_after_count: assert property (p_lock_after_count)
        else $error("lock rose without reacquire");

    property p_sec_off;
        !ctrl_q[pll_pkg::CTRL_SEC_EN] |=> !global_clock_net_one;
    endproperty
    a_sec_off: assert property (p_sec_off)
        else $error("secondary net driven while disabled");

    property p_sec_div_idle;
        !ctrl_q[pll_pkg::CTRL_SEC_EN] |=> !sec_level;
    endproperty
    a_sec_div_idle: assert property (p_sec_div_idle)
        else $error("secondary divider ran while disabled");

    property p_post_bypass;
        (div_post_q == DIV_W'(1) && !loop_rst_q) ##1 !loop_rst_q
            |=> global_clock_net_zero == $past(vco_level, 2);
    endproperty
    a_post_bypass: assert property (p_post_bypass)
        else $error("primary net does not follow oscillator");

    property p_fb_internal;
        !ctrl_q[pll_pkg::CTRL_FB_PIN] && !ctrl_q[pll_pkg::CTRL_DLY_FB]
            |-> fb_level == global_clock_net_zero;
    endproperty
    a_fb_internal: assert property (p_fb_internal)
        else $error("feedback not taken from own net");

    property p_reset_pin;
        !ctrl_q[pll_pkg::CTRL_SOFT_RST] && ctrl_q[pll_pkg::CTRL_RST_PIN] && rst_pin_s
            |=> loop_rst_q ##1 !loop_lock;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin did not reset loop");

    property p_step_up;
        ref_tick && fb_cnt_q == 2'h0 && !loop_rst_q
            && step_q <= pll_pkg::STEP_MAX - pll_pkg::STEP_GAIN
            |=> step_q == $past(step_q) + pll_pkg::STEP_GAIN;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("slow feedback did not raise step");

    property p_step_down;
        ref_tick && fb_cnt_q >= 2'h2 && !loop_rst_q && step_q > pll_pkg::STEP_GAIN
            |=> step_q == $past(step_q) - pll_pkg::STEP_GAIN;
    endproperty
    a_step_down: assert property (p_step_down)
        else $error("fast feedback did not lower step");

    property p_ref_delay0;
        dly_q == '0 && !ctrl_q[pll_pkg::CTRL_DLY_FB] && $stable(ctrl_q)
            |-> ref_level == $past(ref_s);
    endproperty
    a_ref_delay0: assert property (p_ref_delay0)
        else $error("reference delay tap wrong");

    c_lock: cover property ($rose(loop_lock));
    c_secondary: cover property (ctrl_q[pll_pkg::CTRL_SEC_EN] && $rose(global_clock_net_one));
    c_fb_pin_lock: cover property (ctrl_q[pll_pkg::CTRL_FB_PIN] && $rose(loop_lock));
    c_dly_fb: cover property (ctrl_q[pll_pkg::CTRL_DLY_FB] && dly_q != '0 && fb_tick);
endmodule : pll_clock_synthesis

// >>> testbench/fabric_clock_model.sv
// Fabric-side model: reference source, board feedback path, clock edge counters
`timescale 1ns/1ns
module fabric_clock_model (
    input wire logic clk, // System clock
    input wire logic rst_b, // Bench reset, active low
    input wire logic fb_broken, // Feedback wire left floating
    input wire logic net_zero, // Primary clock net
    input wire logic net_one, // Secondary clock net
    output logic ref_pin, // Reference clock, clk/16
    output logic fb_pin, // Feedback pin
    output logic [15:0] rises_zero, // Rising edges seen on net zero
    output logic [15:0] rises_one // Rising edges seen on net one
);
    logic [2:0] phase_q;
    logic zero_q;
    logic one_q;

    // Reference kept well below clk/4
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_q <= 3'h0;
            ref_pin <= 1'b0;
        end else begin
            phase_q <= phase_q + 3'h1;
            if (phase_q == 3'h7) begin
                ref_pin <= ~ref_pin;
            end
        end
    end

    // Floating wire toggles so no stale level passes for feedback
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fb_pin <= 1'b0;
        end else begin
            fb_pin <= fb_broken ? ~fb_pin : net_zero;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            zero_q <= 1'b0;
            one_q <= 1'b0;
            rises_zero <= 16'h0000;
            rises_one <= 16'h0000;
        end else begin
            zero_q <= net_zero;
            one_q <= net_one;
            rises_zero <= rises_zero + 16'(net_zero && !zero_q);
            rises_one <= rises_one + 16'(net_one && !one_q);
        end
    end
endmodule : fabric_clock_model

// >>> testbench/pll_clock_synthesis_bench.sv
// Self-checking bench for one clock synthesis loop
`timescale 1ns/1ns
module pll_clock_synthesis_bench;
    logic clk, rst_b, ref_pin, fb_pin, rst_pin, rst_fab, wr, rd, fb_broken;
    logic net_zero, net_one, lock;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [15:0] rises_zero, rises_one;
    int failures = 0;
    int n_compared = 0;

    pll_clock_synthesis pll_clock_synthesis_inst (
        .clk(clk), .rst_b(rst_b), .global_clock_pin_zero(ref_pin),
        .loop_feedback_in(fb_pin), .loop_reset_pin(rst_pin), .loop_reset_fabric(rst_fab),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .global_clock_net_zero(net_zero), .global_clock_net_one(net_one), .loop_lock(lock)
    );

    fabric_clock_model fabric_clock_model_inst (
        .clk(clk), .rst_b(rst_b), .fb_broken(fb_broken), .net_zero(net_zero),
        .net_one(net_one), .ref_pin(ref_pin), .fb_pin(fb_pin),
        .rises_zero(rises_zero), .rises_one(rises_one)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic wait_lock();
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
            #1;
            if (lock === 1'b1) break;
        end
        check(32'(lock), 32'h1, "lock not reached");
        if (lock !== 1'b1) print_verdict();
    endtask : wait_lock

    task automatic restart(input logic [31:0] ctrl, m, n, v);
        wr_reg(pll_pkg::ADDR_CTRL, ctrl | (32'h1 << pll_pkg::CTRL_SOFT_RST));
        wr_reg(pll_pkg::ADDR_DIV_IN, m);
        wr_reg(pll_pkg::ADDR_DIV_FB, n);
        wr_reg(pll_pkg::ADDR_DIV_POST, v);
        wr_reg(pll_pkg::ADDR_CTRL, ctrl);
        wait_lock();
        // First lock comes before the frequency has fully settled
        repeat (3000) @(posedge clk);
    endtask : restart

    task automatic measure(input logic [15:0] exp0, exp1, tol1, input string what);
        logic [15:0] r0, r1, d0, d1;
        r0 = rises_zero;
        r1 = rises_one;
        repeat (1600) @(posedge clk);
        d0 = rises_zero - r0;
        d1 = rises_one - r1;
        check(32'(d0 + 16'h4 >= exp0 && d0 <= exp0 + 16'h4), 32'h1, what);
        check(32'(d1 + tol1 >= exp1 && d1 <= exp1 + tol1), 32'h1, what);
    endtask : measure

    task automatic expect_held(input string what);
        logic [31:0] d;
        logic [15:0] r0;
        repeat (8) @(posedge clk);
        r0 = rises_zero;
        rd_reg(pll_pkg::ADDR_STATUS, d);
        check(d, 32'h2, what);
        repeat (64) @(posedge clk);
        check(32'(rises_zero - r0), 32'h0, what);
        check(32'(lock), 32'h0, what);
    endtask : expect_held

    task automatic relock();
        repeat (40) @(posedge clk);
        check(32'(lock), 32'h0, "early lock");
        wait_lock();
    endtask : relock

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_registers();
        logic [7:0] a [8] = '{pll_pkg::ADDR_CTRL, pll_pkg::ADDR_DIV_IN, pll_pkg::ADDR_DIV_FB,
            pll_pkg::ADDR_DIV_POST, pll_pkg::ADDR_DIV_SEC, pll_pkg::ADDR_DELAY,
            pll_pkg::ADDR_STATUS, 8'h1C};
        logic [31:0] e [8] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            rd_reg(a[i], d);
            check(d, e[i], "reset value");
        end
        @(posedge clk);
        #1;
        check(rdata, 32'h0, "rdata after read");
        wr_reg(pll_pkg::ADDR_CTRL, 32'hFFFF_FFEF);
        rd_reg(pll_pkg::ADDR_CTRL, d);
        check(d, 32'h0000_000F, "ctrl width");
        wr_reg(pll_pkg::ADDR_CTRL, 32'h0);
        wr_reg(pll_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rd_reg(pll_pkg::ADDR_STATUS, d);
        check(d, 32'h0, "status read only");
        wr_reg(pll_pkg::ADDR_DELAY, 32'hFFFF_FFFF);
        rd_reg(pll_pkg::ADDR_DELAY, d);
        check(d, 32'h0000_000F, "delay tap");
    endtask : test_registers

    task automatic test_ratios();
        logic [31:0] t [4][4] = '{'{32'h1, 32'h1, 32'h1, 32'd100},
            '{32'h1, 32'h2, 32'h1, 32'd200}, '{32'h2, 32'h2, 32'h1, 32'd100},
            '{32'h1, 32'h2, 32'h2, 32'd100}};
        for (int i = 0; i < 4; i++) begin
            restart(32'h0, t[i][0], t[i][1], t[i][2]);
            measure(t[i][3][15:0], 16'h0, 16'h0, "primary ratio");
        end
    endtask : test_ratios

    task automatic test_secondary();
        restart(32'h1 << pll_pkg::CTRL_SEC_EN, 32'h1, 32'h1, 32'h1);
        wr_reg(pll_pkg::ADDR_DIV_SEC, 32'h2);
        measure(16'd100, 16'd50, 16'h3, "secondary half");
        wr_reg(pll_pkg::ADDR_DIV_SEC, 32'h4);
        measure(16'd100, 16'd25, 16'h3, "secondary quarter");
    endtask : test_secondary

    task automatic test_reset_sources();
        logic [31:0] d;
        restart(32'h0, 32'h1, 32'h1, 32'h1);
        @(posedge clk);
        rst_pin <= 1'b1;
        repeat (64) @(posedge clk);
        rd_reg(pll_pkg::ADDR_STATUS, d);
        check(d & 32'h2, 32'h0, "pin ignored");
        wr_reg(pll_pkg::ADDR_CTRL, 32'h1 << pll_pkg::CTRL_RST_PIN);
        expect_held("pin reset");
        @(posedge clk);
        rst_pin <= 1'b0;
        relock();
        wr_reg(pll_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk);
        rst_fab <= 1'b1;
        expect_held("fabric reset");
        @(posedge clk);
        rst_fab <= 1'b0;
        relock();
        wr_reg(pll_pkg::ADDR_CTRL, 32'h1 << pll_pkg::CTRL_SOFT_RST);
        expect_held("soft reset");
        wr_reg(pll_pkg::ADDR_CTRL, 32'h0);
        relock();
    endtask : test_reset_sources

    task automatic test_feedback_pin();
        restart(32'h1 << pll_pkg::CTRL_FB_PIN | 32'h1 << pll_pkg::CTRL_DLY_FB,
            32'h1, 32'h1, 32'h1);
        measure(16'd100, 16'h0, 16'h0, "pin feedback");
        @(posedge clk);
        fb_broken <= 1'b1;
        repeat (64) @(posedge clk);
        check(32'(lock), 32'h0, "broken feedback");
        @(posedge clk);
        fb_broken <= 1'b0;
    endtask : test_feedback_pin

    // ----------------------------------------
    // Clock and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        rst_pin = 1'b0;
        rst_fab = 1'b0;
        fb_broken = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        test_registers();
        test_ratios();
        test_secondary();
        test_reset_sources();
        test_feedback_pin();
        print_verdict();
    end
endmodule : pll_clock_synthesis_bench
